// [fltcfg_lock_det.sv]
/*
  fltcfg_lock_det: one lock-current detector, level and rising pulse.
  Assumes current samples and threshold in milliamps on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fltcfg_lock_det
  import fltcfg_pkg::*;
#(
  parameter int unsigned CW = FLTCFG_CW
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // sample in
  input wire logic sample_valid,
  input wire logic [CW-1:0] current_ma,
  input wire logic [CW-1:0] threshold_ma,
  // indication out
  output var fltcfg_lock_s det
);
  fltcfg_lock_s next_det;
  logic over;

  always_comb begin
    over = current_ma > threshold_ma;
    next_det.lock = det.lock;
    next_det.rise = 1'b0;
    if (sample_valid) begin
      next_det.lock = over;
      next_det.rise = over && !det.lock;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      det <= '0;
    end else begin
      det <= next_det;
    end
  end

  property p_lock_follows;
    @(posedge ref_clk) disable iff (!rst_b)
      sample_valid |=> (det.lock == $past(over));
  endproperty
  a_lock_follows: assert property (p_lock_follows)
    else $error("lock level does not follow compare");

  property p_rise_once;
    @(posedge ref_clk) disable iff (!rst_b)
      det.rise |-> det.lock && !$past(det.lock);
  endproperty
  a_rise_once: assert property (p_rise_once)
    else $error("rise pulse without new lock");
endmodule
`default_nettype wire

// [fltcfg_pkg.sv]
/*
  fltcfg_pkg: shared constants and types of the fault settings block.
  Assumes a 32-bit Avalon-MM register bus and currents in milliamps.
*/
`default_nettype none
package fltcfg_pkg;
  localparam int unsigned FLTCFG_AW = 8;
  localparam int unsigned FLTCFG_CW = 14;
  // register byte addresses
  localparam logic [7:0] FLTCFG_OFS_SETTINGS = 8'h90;
  localparam logic [7:0] FLTCFG_OFS_STATUS = 8'h94;
  localparam logic [7:0] FLTCFG_OFS_CLEAR = 8'h98;
  localparam logic [7:0] FLTCFG_OFS_ENABLE = 8'h9C;
  localparam logic [31:0] FLTCFG_SETTINGS_RST = 32'h00000000;
  // field positions inside fault_settings_a
  localparam int unsigned FLTCFG_POS_PARITY = 31;
  localparam int unsigned FLTCFG_POS_ILIMIT = 27;
  localparam int unsigned FLTCFG_POS_CMP_THR = 23;
  localparam int unsigned FLTCFG_POS_ADC_THR = 19;
  localparam int unsigned FLTCFG_POS_NVM_RESP = 18;
  // status, clear and enable bits
  localparam int unsigned FLTCFG_EV_CMP_LOCK = 0;
  localparam int unsigned FLTCFG_EV_ADC_LOCK = 1;
  localparam int unsigned FLTCFG_EV_NVM = 2;
  localparam int unsigned FLTCFG_EV_N = 3;
  localparam logic [2:0] FLTCFG_EV_RST = 3'h0;
  // current scale points in milliamps
  localparam logic [13:0] FLTCFG_MA_CODE0 = 14'h007D;
  localparam logic [13:0] FLTCFG_MA_CODE1 = 14'h00FA;
  localparam logic [13:0] FLTCFG_MA_CODE2 = 14'h01F4;
  localparam logic [13:0] FLTCFG_MA_LIN_BASE = 14'h03E8;
  localparam logic [13:0] FLTCFG_MA_LIN_STEP = 14'h01F4;
  localparam logic [13:0] FLTCFG_MA_CODEE = 14'h1B58;
  localparam logic [13:0] FLTCFG_MA_CODEF = 14'h1F40;
  localparam logic [3:0] FLTCFG_LIN_FIRST = 4'h3;

  typedef struct packed {
    logic parity;
    logic [3:0] torque_limit;
    logic [3:0] comparator_lock_threshold;
    logic [3:0] converter_lock_threshold;
    logic nvm_fault_response;
    logic [17:0] other_fields;
  } fltcfg_settings_s;

  typedef struct packed {
    logic lock;
    logic rise;
  } fltcfg_lock_s;

  // nonlinear 16-step current scale, code to milliamps
  function automatic logic [13:0] fltcfg_code_ma(input logic [3:0] code);
    logic [3:0] k;
    k = code - FLTCFG_LIN_FIRST;
    unique case (code)
      4'h0: fltcfg_code_ma = FLTCFG_MA_CODE0;
      4'h1: fltcfg_code_ma = FLTCFG_MA_CODE1;
      4'h2: fltcfg_code_ma = FLTCFG_MA_CODE2;
      4'hE: fltcfg_code_ma = FLTCFG_MA_CODEE;
      4'hF: fltcfg_code_ma = FLTCFG_MA_CODEF;
      default: fltcfg_code_ma = 14'(FLTCFG_MA_LIN_BASE
                                    + 14'(k) * FLTCFG_MA_LIN_STEP);
    endcase
  endfunction
endpackage
`default_nettype wire

// [fltcfg_top.sv]
/*
  fltcfg_top: fault settings register with lock detectors and interrupt.
  Assumes an Avalon-MM master with waitrequest on ref_clk, synchronous
  current samples and a one-cycle nvm fault pulse from the memory block.
*/
// Our own choice: the Avalon-MM register port.
// What this block does
// - one 32-bit register at 90h, resets zero
// - bits 30-27 pick torque current limit
// - bits 26-23 comparator lock threshold, same scale
// - bits 22-19 converter lock threshold, same scale
// - bit 18: zero latches and reports, one only reports nvm fault
`timescale 1ns/1ns
`default_nettype none
module fltcfg_top
  import fltcfg_pkg::*;
#(
  parameter int unsigned CW = FLTCFG_CW
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [FLTCFG_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // current measurements
  input wire logic [CW-1:0] comparator_current_ma,
  input wire logic converter_sample_valid,
  input wire logic [CW-1:0] converter_current_ma,
  // nvm fault event
  input wire logic nvm_fault,
  // outputs to the control loop and fault handler
  output logic [CW-1:0] torque_limit_ma,
  output logic comparator_lock,
  output logic converter_lock,
  output logic nvm_fault_latched,
  output logic nvm_fault_report,
  output logic irq
);
  fltcfg_settings_s settings, next_settings;
  logic [FLTCFG_EV_N-1:0] status, next_status;
  logic [FLTCFG_EV_N-1:0] enable, next_enable;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic [CW-1:0] next_torque;
  logic [CW-1:0] cmp_thr_ma, adc_thr_ma;
  logic next_latched, next_report, next_irq;
  logic req, wr_go;
  logic [FLTCFG_EV_N-1:0] ev, clr;
  fltcfg_lock_s cmp_det, adc_det;

  function automatic logic [31:0] fltcfg_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // bus handshake: one wait cycle, then a single-cycle answer
  always_comb begin
    req = avs_read || avs_write;
    wr_go = avs_write && !avs_waitrequest;
    next_waitrequest = !(req && avs_waitrequest);
    next_readdata = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        FLTCFG_OFS_SETTINGS: next_readdata = settings;
        FLTCFG_OFS_STATUS: next_readdata = 32'(status);
        FLTCFG_OFS_ENABLE: next_readdata = 32'(enable);
        default: next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  // register writes
  always_comb begin
    next_settings = settings;
    next_enable = enable;
    clr = '0;
    if (wr_go) begin
      unique case (avs_address)
        FLTCFG_OFS_SETTINGS: next_settings =
          fltcfg_merge(settings, avs_writedata, avs_byteenable);
        FLTCFG_OFS_ENABLE: next_enable = FLTCFG_EV_N'(fltcfg_merge(
          32'(enable), avs_writedata, avs_byteenable));
        FLTCFG_OFS_CLEAR: clr = avs_byteenable[0] ?
          avs_writedata[FLTCFG_EV_N-1:0] : '0;
        default: next_settings = settings;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      settings <= FLTCFG_SETTINGS_RST;
      enable <= FLTCFG_EV_RST;
    end else begin
      settings <= next_settings;
      enable <= next_enable;
    end
  end

  assign cmp_thr_ma = CW'(fltcfg_code_ma(settings.comparator_lock_threshold));
  assign adc_thr_ma = CW'(fltcfg_code_ma(settings.converter_lock_threshold));

  fltcfg_lock_det #(.CW(CW)) u_cmp_det (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample_valid(1'b1),
    .current_ma(comparator_current_ma),
    .threshold_ma(cmp_thr_ma),
    .det(cmp_det)
  );

  fltcfg_lock_det #(.CW(CW)) u_adc_det (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sample_valid(converter_sample_valid),
    .current_ma(converter_current_ma),
    .threshold_ma(adc_thr_ma),
    .det(adc_det)
  );

  // events, status, nvm response and interrupt
  always_comb begin
    ev = '0;
    ev[FLTCFG_EV_CMP_LOCK] = cmp_det.rise;
    ev[FLTCFG_EV_ADC_LOCK] = adc_det.rise;
    ev[FLTCFG_EV_NVM] = nvm_fault;
    // set wins over a clear in the same cycle
    next_status = (status & ~clr) | ev;
    next_irq = |(next_status & next_enable);
    next_torque = CW'(fltcfg_code_ma(settings.torque_limit));
    next_latched = nvm_fault_latched;
    if (clr[FLTCFG_EV_NVM]) begin
      next_latched = 1'b0;
    end
    if (nvm_fault && !settings.nvm_fault_response) begin
      next_latched = 1'b1;
    end
    next_report = nvm_fault;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      status <= FLTCFG_EV_RST;
      irq <= 1'b0;
      torque_limit_ma <= '0;
      nvm_fault_latched <= 1'b0;
      nvm_fault_report <= 1'b0;
    end else begin
      status <= next_status;
      irq <= next_irq;
      torque_limit_ma <= next_torque;
      nvm_fault_latched <= next_latched;
      nvm_fault_report <= next_report;
    end
  end

  // lock levels registered once more so outputs stay flop-driven
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      comparator_lock <= 1'b0;
      converter_lock <= 1'b0;
    end else begin
      comparator_lock <= cmp_det.lock;
      converter_lock <= adc_det.lock;
    end
  end

  sequence s_settings_write;
    avs_write && !avs_waitrequest && avs_address == FLTCFG_OFS_SETTINGS
      && avs_byteenable == 4'hF;
  endsequence

  property p_reset_zero;
    @(posedge ref_clk) $rose(rst_b) |-> settings == 32'h00000000;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("settings not zero after reset");

  // no write can land in the wait cycle of a read, so the word stands
  sequence s_settings_read;
    avs_read && !avs_waitrequest && avs_address == FLTCFG_OFS_SETTINGS;
  endsequence

  property p_readback;
    @(posedge ref_clk) disable iff (!rst_b)
      s_settings_read |-> avs_readdata == settings;
  endproperty
  a_readback: assert property (p_readback)
    else $error("settings readback mismatch");

  property p_torque;
    @(posedge ref_clk) disable iff (!rst_b)
      s_settings_write |-> ##2 torque_limit_ma ==
        CW'(fltcfg_code_ma($past(avs_writedata[30:27], 2)));
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque limit not decoded from bits 30-27");

  property p_cmp_thr;
    @(posedge ref_clk) disable iff (!rst_b)
      s_settings_write |=> settings.comparator_lock_threshold ==
        $past(avs_writedata[26:23]);
  endproperty
  a_cmp_thr: assert property (p_cmp_thr)
    else $error("comparator threshold not from bits 26-23");

  property p_adc_thr;
    @(posedge ref_clk) disable iff (!rst_b)
      s_settings_write |=> adc_thr_ma ==
        CW'(fltcfg_code_ma($past(avs_writedata[22:19])));
  endproperty
  a_adc_thr: assert property (p_adc_thr)
    else $error("converter threshold not from bits 22-19");

  property p_nvm_report_only;
    @(posedge ref_clk) disable iff (!rst_b)
      nvm_fault && settings.nvm_fault_response && !nvm_fault_latched
        |=> !nvm_fault_latched && nvm_fault_report;
  endproperty
  a_nvm_report_only: assert property (p_nvm_report_only)
    else $error("report-only nvm fault was latched");

  property p_nvm_latch;
    @(posedge ref_clk) disable iff (!rst_b)
      nvm_fault && !settings.nvm_fault_response |=> nvm_fault_latched;
  endproperty
  a_nvm_latch: assert property (p_nvm_latch)
    else $error("nvm fault not latched");

  property p_cmp_lock;
    @(posedge ref_clk) disable iff (!rst_b)
      comparator_current_ma > cmp_thr_ma ##1 1'b1 |=> comparator_lock;
  endproperty
  a_cmp_lock: assert property (p_cmp_lock)
    else $error("comparator lock missing above threshold");
endmodule
`default_nettype wire

// [fltcfg_top_bench.sv]
/*
  fltcfg_top_bench: self-checking bench of the fault settings block.
  Assumes fltcfg_pkg and fltcfg_top compiled first; ref_clk at 100 MHz.
*/
`timescale 1ns/1ns
`default_nettype none
module fltcfg_top_bench;
  import fltcfg_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] comparator_current_ma = 14'h0000;
  logic converter_sample_valid = 1'b0;
  logic [13:0] converter_current_ma = 14'h0000;
  logic nvm_fault = 1'b0;
  logic [13:0] torque_limit_ma;
  logic comparator_lock;
  logic converter_lock;
  logic nvm_fault_latched;
  logic nvm_fault_report;
  logic irq;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] rdata;

  always #5 ref_clk = ~ref_clk;

  fltcfg_top u_fltcfg_top (
    .ref_clk(ref_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .comparator_current_ma(comparator_current_ma),
    .converter_sample_valid(converter_sample_valid),
    .converter_current_ma(converter_current_ma),
    .nvm_fault(nvm_fault), .torque_limit_ma(torque_limit_ma),
    .comparator_lock(comparator_lock), .converter_lock(converter_lock),
    .nvm_fault_latched(nvm_fault_latched),
    .nvm_fault_report(nvm_fault_report), .irq(irq)
  );

  task automatic complete_run();
    $display("compares %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg,
               seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      $display("wrong value at %0t: bus answer timed out", $time);
      complete_run();
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h00000000);
    check(rdata, e, m);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // bench copy of the current scale, milliamps
  function automatic logic [13:0] exp_ma(input logic [3:0] c);
    case (c)
      4'h0: return 14'h007D;
      4'h1: return 14'h00FA;
      4'h2: return 14'h01F4;
      4'hE: return 14'h1B58;
      4'hF: return 14'h1F40;
      default: return 14'h03E8 + 14'(c - 4'h3) * 14'h01F4;
    endcase
  endfunction

  task automatic t_limit();
    logic [31:0] d;
    for (int c = 0; c < 16; c++) begin
      d = {1'b1, 4'(c), 4'(15 - c), 4'(c), 1'b1, 18'h2AAAA};
      wr(FLTCFG_OFS_SETTINGS, d);
      settle(2);
      check(32'(torque_limit_ma), 32'(exp_ma(4'(c))), "torque limit");
      rd(FLTCFG_OFS_SETTINGS, d, "settings readback");
    end
  endtask

  task automatic cmp_step(input logic [13:0] v, input logic e);
    @(posedge ref_clk);
    comparator_current_ma <= v;
    settle(3);
    check(32'(comparator_lock), 32'(e), "comparator lock");
  endtask

  task automatic t_cmp();
    logic [3:0] codes [3] = '{4'h0, 4'h5, 4'hF};
    foreach (codes[i]) begin
      wr(FLTCFG_OFS_SETTINGS, 32'(codes[i]) << 23);
      cmp_step(exp_ma(codes[i]), 1'b0);
      cmp_step(exp_ma(codes[i]) + 14'h0001, 1'b1);
      cmp_step(14'h0000, 1'b0);
    end
    // interrupt: masked, cleared, raised again
    wr(FLTCFG_OFS_ENABLE, 32'h00000001);
    settle(2);
    check(32'(irq), 32'h00000001, "irq enabled");
    rd(FLTCFG_OFS_STATUS, 32'h00000001, "comparator status");
    wr(FLTCFG_OFS_ENABLE, 32'h00000000);
    settle(2);
    check(32'(irq), 32'h00000000, "irq masked");
    wr(FLTCFG_OFS_CLEAR, 32'h00000001);
    rd(FLTCFG_OFS_STATUS, 32'h00000000, "status cleared");
    wr(FLTCFG_OFS_ENABLE, 32'h00000001);
    cmp_step(14'h1F41, 1'b1);
    check(32'(irq), 32'h00000001, "irq on rise");
    wr(FLTCFG_OFS_CLEAR, 32'h00000001);
    cmp_step(14'h0000, 1'b0);
    check(32'(irq), 32'h00000000, "irq after clear");
  endtask

  // samples outside the valid pulse carry junk on purpose
  task automatic adc_step(input logic [13:0] v, input logic e);
    @(posedge ref_clk);
    converter_sample_valid <= 1'b1;
    converter_current_ma <= v;
    @(posedge ref_clk);
    converter_sample_valid <= 1'b0;
    converter_current_ma <= ~v;
    settle(3);
    check(32'(converter_lock), 32'(e), "converter lock");
  endtask

  task automatic t_adc();
    wr(FLTCFG_OFS_SETTINGS, 32'h02980000);
    adc_step(14'h03E9, 1'b1);
    adc_step(14'h03E8, 1'b0);
    wr(FLTCFG_OFS_SETTINGS, 32'h00700000);
    adc_step(14'h1B59, 1'b1);
    adc_step(14'h1B58, 1'b0);
    rd(FLTCFG_OFS_STATUS, 32'h00000002, "converter status");
    wr(FLTCFG_OFS_CLEAR, 32'h00000007);
  endtask

  task automatic t_nvm(input logic resp);
    wr(FLTCFG_OFS_SETTINGS, 32'(resp) << 18);
    @(posedge ref_clk);
    nvm_fault <= 1'b1;
    @(posedge ref_clk);
    nvm_fault <= 1'b0;
    #1;
    check(32'(nvm_fault_report), 32'h00000001, "nvm report");
    check(32'(nvm_fault_latched), 32'(!resp), "nvm latch");
    settle(1);
    check(32'(nvm_fault_report), 32'h00000000, "nvm report width");
    check(32'(nvm_fault_latched), 32'(!resp), "nvm latch held");
    rd(FLTCFG_OFS_STATUS, 32'h00000004, "nvm status");
    wr(FLTCFG_OFS_CLEAR, 32'h00000004);
    settle(2);
    check(32'(nvm_fault_latched), 32'h00000000, "nvm latch cleared");
  endtask

  task automatic t_refuse();
    rd(8'h40, 32'h00000000, "unmapped read");
    wr(8'h40, 32'hFFFFFFFF);
    wr(FLTCFG_OFS_STATUS, 32'h00000007);
    rd(FLTCFG_OFS_STATUS, 32'h00000000, "status read only");
    rd(FLTCFG_OFS_CLEAR, 32'h00000000, "clear reads zero");
    wr(FLTCFG_OFS_SETTINGS, 32'hFFFFFFFF);
    avs_byteenable <= 4'h1;
    wr(FLTCFG_OFS_SETTINGS, 32'h00000000);
    avs_byteenable <= 4'hF;
    rd(FLTCFG_OFS_SETTINGS, 32'hFFFFFF00, "lane merge");
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(FLTCFG_OFS_SETTINGS, FLTCFG_SETTINGS_RST, "second reset");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    check(32'(avs_waitrequest), 32'h00000001, "idle waitrequest");
    rd(FLTCFG_OFS_SETTINGS, FLTCFG_SETTINGS_RST, "settings reset");
    rd(FLTCFG_OFS_ENABLE, 32'h00000000, "enable reset");
    t_limit();
    t_cmp();
    t_adc();
    t_nvm(1'b0);
    t_nvm(1'b1);
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
